// ==== bench/prx_mac_model.sv ====
// Behavioural MAC controller on the MII side of the receive block.
`timescale 1ns/1ps
`default_nettype none
module prx_mac_model
  import prx_pkg::*;
(
  input wire logic clk_in,
  input wire logic rx_clk_in,
  input wire logic [3:0] rxd_in,
  input wire logic dv_in,
  input wire logic er_in,
  input wire logic tx_clk_in,
  input wire logic rmii_in,
  output var prx_entry_t seen_out,
  output logic seen_stb_out,
  output logic [3:0] txd_out,
  output logic tx_en_out
);
  logic rx_q = 1'b1;
  logic [3:0] txq[$];
  initial txd_out = 4'h0;
  initial tx_en_out = 1'b0;
  task automatic send(input logic [3:0] n);
    txq.push_back(n);
  endtask
  // Sampling one system edge after the receive clock rises keeps clear of the launch edge.
  always @(posedge clk_in) begin
    rx_q <= rx_clk_in;
    seen_stb_out <= rx_clk_in && !rx_q && (dv_in || er_in);
    seen_out <= '{dv_in, er_in, rxd_in};
  end
  // Outside RMII, idle data lines toggle so that a stale value is never mistaken for data; under RMII they are held at zero.
  always @(negedge tx_clk_in) begin
    tx_en_out <= txq.size() > 0;
    txd_out <= txq.size() > 0 ? txq.pop_front() : (rmii_in ? 4'h0 : ~txd_out);
  end
endmodule
`default_nettype wire

// ==== bench/prx_top_monitor.sv ====
// Concurrent checks on the ports of the receive coding block.
`timescale 1ns/1ps
`default_nettype none
module prx_top_monitor (
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  input wire logic S_AXI_AWREADY_OUT,
  input wire logic S_AXI_WREADY_OUT,
  input wire logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_ARREADY_OUT,
  input wire logic S_AXI_RVALID_OUT,
  input wire logic RX_CLK_OUT,
  input wire logic [3:0] RXD_OUT,
  input wire logic RX_DV_OUT,
  input wire logic RX_ER_OUT,
  input wire logic COL_OUT,
  input wire logic TX_CLK_OUT,
  input wire logic TX_NIBBLE_VALID_OUT
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (SRST_IN);
  ////////////////////////////////////////////////////////////
  AST_COL_LOW: assert property (COL_OUT == 1'b0)
    else $error("collision raised");
  AST_DV_ON_FALL: assert property ($rose(RX_DV_OUT) |-> $fell(RX_CLK_OUT))
    else $error("data valid rose off the falling receive clock");
  AST_BAD_SSD: assert property (RX_ER_OUT && !RX_DV_OUT |-> RXD_OUT == 4'he)
    else $error("bad start delimiter without 1110");
  AST_TXV_GAP: assert property (TX_NIBBLE_VALID_OUT |=> !TX_NIBBLE_VALID_OUT [*8])
    else $error("transmit nibbles too close");
  AST_TXV_CLK: assert property (TX_NIBBLE_VALID_OUT |-> TX_CLK_OUT)
    else $error("transmit nibble not tied to the rising transmit clock");
  AST_AW_W: assert property (S_AXI_AWREADY_OUT == S_AXI_WREADY_OUT)
    else $error("address and data ready differ");
  AST_B_AW: assert property ($rose(S_AXI_BVALID_OUT) |-> S_AXI_AWREADY_OUT)
    else $error("write response without address take");
  AST_R_AR: assert property ($rose(S_AXI_RVALID_OUT) |-> S_AXI_ARREADY_OUT)
    else $error("read data without address take");
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the receive coding and MAC interface block.
`include "prx_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import prx_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awa = 8'h0, ara = 8'h0;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wrd, bv, arr, rv, rxc, txc, dv, er, txv, tx_en, stb;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] rxd, txn, txd, v;
  prx_entry_t seen;
  logic [1:0] lvl = 2'b00;
  logic tgl = 1'b0, sig = 1'b1, lf = 1'b0, byp = 1'b0, crs;
  int n_errors = 0, comparisons = 0, ph = 0, seed = 32'h651a;
  logic [10:0] key;
  prx_entry_t rxq[$];
  logic [3:0] txq[$];
  logic [4:0] dc [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  always #2.5 clk = ~clk;
  prx_top #(.IDLE_WINDOW_CYCLES(4000)) i_dut (
    .SYS_CLK_IN(clk), .SRST_IN(rst), .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hf),
    .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br), .S_AXI_ARADDR_IN(ara),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr),
    .LINE_LEVEL_IN(lvl), .LINE_TOGGLE_IN(tgl), .LINE_SIGNAL_PRESENT_IN(sig),
    .LINK_FAIL_IN(lf), .TXD_IN(txd), .TX_EN_IN(tx_en), .RX_CLK_OUT(rxc),
    .TX_CLK_OUT(txc), .RXD_OUT(rxd), .RX_DV_OUT(dv), .RX_ER_OUT(er), .CRS_OUT(crs),
    .COL_OUT(), .TX_NIBBLE_OUT(txn), .TX_NIBBLE_VALID_OUT(txv));
  prx_mac_model i_mac (.clk_in(clk), .rx_clk_in(rxc), .rxd_in(rxd), .dv_in(dv),
    .er_in(er), .tx_clk_in(txc), .rmii_in(1'b0), .seen_out(seen), .seen_stb_out(stb),
    .txd_out(txd), .tx_en_out(tx_en));
  ////////////////////////////////////////////////////////////
  task automatic close_out();
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    close_out();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    if (n == 50) hang();
    br <= 1'b0;
    chk(32'(bresp), 32'(r));
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    if (n == 50) hang();
    rr <= 1'b0;
    chk(rdata, e);
    chk(32'(rresp), 32'(r));
    @(posedge clk);
  endtask
  // One line bit: scramble, NRZI, then step the three-level line.
  task automatic bit_out(input logic b);
    logic kb;
    kb = key[10] ^ key[8];
    key = {key[9:0], kb};
    if (b ^ (kb & !byp)) ph = ph + 1;
    lvl <= ph[0] ? 2'b00 : (ph[1] ? 2'b10 : 2'b01);
    tgl <= ~tgl;
    repeat (15) @(posedge clk);
  endtask
  task automatic sym(input logic [4:0] c);
    for (int i = 4; i >= 0; i--) bit_out(c[i]);
  endtask
  task automatic idles(input int n);
    repeat (n) sym(`PRX_CODE_IDLE);
  endtask
  task automatic ex(input logic d, input logic e, input logic [3:0] x);
    rxq.push_back('{d, e, x});
  endtask
  // Expectations go in before the symbols, as the answer may beat the task's return.
  task automatic jk();
    ex(1'b1, 1'b0, 4'h5);
    ex(1'b1, 1'b0, 4'h5);
    sym(`PRX_CODE_J);
    sym(`PRX_CODE_K);
  endtask
  task automatic drain();
    int n;
    for (n = 0; n < 4000 && rxq.size() + txq.size() > 0; n++) @(posedge clk);
    if (n == 4000) hang();
  endtask
  always @(posedge clk) begin
    if (stb === 1'b1) chk(32'(seen), rxq.size() > 0 ? 32'(rxq.pop_front()) : 32'hdead);
    if (txv === 1'b1) chk(32'(txn), txq.size() > 0 ? 32'(txq.pop_front()) : 32'hdead);
  end
  initial begin
    key = 11'($random(seed)) | 11'h1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axi_rd(8'h00, 32'h0, 2'b00);
    axi_rd(8'h7c, 32'h40, 2'b00);
    axi_rd(8'h40, 32'h0, 2'b10);
    axi_wr(8'h40, 32'hffff_ffff, 2'b10);
    axi_wr(8'h00, 32'h6, 2'b00);
    axi_rd(8'h00, 32'h6, 2'b00);
    idles(12);
    axi_rd(8'h04, 32'h1, 2'b00);
    jk();
    chk(32'(crs), 32'h1);
    for (int i = 0; i < 16; i++) begin
      ex(1'b1, 1'b0, 4'(i));
      sym(dc[i]);
    end
    sym(`PRX_CODE_T);
    sym(`PRX_CODE_R);
    idles(3);
    chk(32'(crs), 32'h0);
    jk();
    ex(1'b1, 1'b1, 4'h0);
    sym(5'h00);
    ex(1'b1, 1'b1, 4'h1);
    sym(5'h01);
    v = 4'($random(seed));
    ex(1'b1, 1'b0, v);
    sym(dc[v]);
    idles(5);
    ex(1'b0, 1'b1, 4'he);
    sym(`PRX_CODE_J);
    idles(4);
    jk();
    ex(1'b1, 1'b0, 4'h2);
    sym(dc[2]);
    repeat (300) @(posedge clk);
    sig <= 1'b0;
    repeat (4) @(posedge clk);
    axi_rd(8'h04, 32'h1, 2'b00);
    sig <= 1'b1;
    idles(4);
    axi_wr(8'h7c, 32'h41, 2'b00);
    byp = 1'b1;
    idles(2);
    jk();
    ex(1'b1, 1'b0, 4'h9);
    sym(dc[9]);
    sym(`PRX_CODE_T);
    sym(`PRX_CODE_R);
    idles(2);
    byp = 1'b0;
    axi_wr(8'h7c, 32'h0, 2'b00);
    jk();
    ex(1'b1, 1'b1, 4'h3);
    sym(5'h13);
    repeat (150) @(posedge clk);
    lf <= 1'b1;
    repeat (4) @(posedge clk);
    axi_rd(8'h04, 32'h1, 2'b00);
    lf <= 1'b0;
    axi_wr(8'h7c, 32'h40, 2'b00);
    idles(4);
    drain();
    for (int k = 0; k < 4; k++) begin
      v = k < 2 ? 4'h5 : 4'($random(seed));
      txq.push_back(v);
      ex(1'b1, 1'b0, v);
      i_mac.send(v);
    end
    drain();
    close_out();
  end
endmodule
bind prx_top prx_top_monitor i_mon (.SYS_CLK_IN(SYS_CLK_IN), .SRST_IN(SRST_IN),
  .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT), .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT),
  .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT), .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
  .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .RX_CLK_OUT(RX_CLK_OUT), .RXD_OUT(RXD_OUT),
  .RX_DV_OUT(RX_DV_OUT), .RX_ER_OUT(RX_ER_OUT), .COL_OUT(COL_OUT),
  .TX_CLK_OUT(TX_CLK_OUT), .TX_NIBBLE_VALID_OUT(TX_NIBBLE_VALID_OUT));
`default_nettype wire

// ==== core/prx_defs.svh ====
// Constant definitions for the receive coding and MAC interface block.
`ifndef PRX_DEFS_SVH
`define PRX_DEFS_SVH

// Register indices; byte address is four times the index.
`define PRX_IDX_CONTROL 6'd0
`define PRX_IDX_STATUS 6'd1
`define PRX_IDX_CONFIG 6'd31
`define PRX_ADDR_LSB 2
`define PRX_ADDR_W 8

// Control register fields.
`define PRX_CTL_RMII 0
`define PRX_CTL_SPEED10 1
`define PRX_CTL_HALF_DUPLEX 2
`define PRX_CTL_RESET 32'h0000_0000

// Configuration register fields.
`define PRX_CFG_DESCR_BYPASS 0
`define PRX_CFG_DECODE_ENABLE 6
`define PRX_CFG_RESET 32'h0000_0040

// Code groups.
`define PRX_CODE_IDLE 5'h1f
`define PRX_CODE_J 5'h18
`define PRX_CODE_K 5'h11
`define PRX_CODE_T 5'h0d
`define PRX_CODE_R 5'h07
`define PRX_NIB_PREAMBLE 4'h5
`define PRX_NIB_BAD_SSD 4'he

// Line level codes: zero, plus, minus.
`define PRX_LEVEL_W 2

// Timing.
`define PRX_CLK_MHZ 200
`define PRX_IDLE_WINDOW_US 40
`define PRX_HALF_25M 7'd4
`define PRX_HALF_50M 7'd2
`define PRX_HALF_2M5 7'd40
`define PRX_LOCK_MATCHES 5'd20
`define PRX_IDLE_RUN 4'd10

// AXI responses.
`define PRX_RESP_OKAY 2'b00
`define PRX_RESP_SLVERR 2'b10

`endif

// ==== core/prx_pkg.sv ====
// Types shared by the receive coding and MAC interface block.
package prx_pkg;

  typedef enum logic [1:0] {
    PRX_ST_HUNT = 2'b00,
    PRX_ST_J = 2'b01,
    PRX_ST_FRAME = 2'b10,
    PRX_ST_T = 2'b11
  } prx_state_t;

  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] data;
  } prx_entry_t;

  typedef struct packed {
    logic valid;
    logic [3:0] nibble;
  } prx_dec_t;

endpackage

// ==== core/prx_top.sv ====
// Receive coding sublayer with MII/RMII MAC interface and AXI4-Lite registers.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`include "prx_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module prx_top
  import prx_pkg::*;
#(
  parameter int unsigned IDLE_WINDOW_CYCLES = `PRX_IDLE_WINDOW_US * `PRX_CLK_MHZ,
  parameter int unsigned QUEUE_DEPTH = 4
) (
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  input wire logic [`PRX_ADDR_W-1:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [`PRX_ADDR_W-1:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic [`PRX_LEVEL_W-1:0] LINE_LEVEL_IN,
  input wire logic LINE_TOGGLE_IN,
  input wire logic LINE_SIGNAL_PRESENT_IN,
  input wire logic LINK_FAIL_IN,
  input wire logic [3:0] TXD_IN,
  input wire logic TX_EN_IN,
  output logic RX_CLK_OUT,
  output logic TX_CLK_OUT,
  output logic [3:0] RXD_OUT,
  output logic RX_DV_OUT,
  output logic RX_ER_OUT,
  output logic CRS_OUT,
  output logic COL_OUT,
  output logic [3:0] TX_NIBBLE_OUT,
  output logic TX_NIBBLE_VALID_OUT
);

  function automatic prx_dec_t decode(input logic [4:0] code);
    prx_dec_t d;
    d.valid = 1'b1;
    case (code)
      5'h1e: d.nibble = 4'h0;
      5'h09: d.nibble = 4'h1;
      5'h14: d.nibble = 4'h2;
      5'h15: d.nibble = 4'h3;
      5'h0a: d.nibble = 4'h4;
      5'h0b: d.nibble = 4'h5;
      5'h0e: d.nibble = 4'h6;
      5'h0f: d.nibble = 4'h7;
      5'h12: d.nibble = 4'h8;
      5'h13: d.nibble = 4'h9;
      5'h16: d.nibble = 4'ha;
      5'h17: d.nibble = 4'hb;
      5'h1a: d.nibble = 4'hc;
      5'h1b: d.nibble = 4'hd;
      5'h1c: d.nibble = 4'he;
      5'h1d: d.nibble = 4'hf;
      default: begin
        d.valid = 1'b0;
        d.nibble = 4'h0;
      end
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers. Every line and MAC transmit pin input passes two flip-flops; the AXI and reset inputs do not.

  localparam int SYNC_W = `PRX_LEVEL_W + 8;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [`PRX_LEVEL_W-1:0] level;
  logic toggle;
  logic sig_present;
  logic link_fail;
  logic [3:0] txd;
  logic tx_en;

  always_ff @(posedge SYS_CLK_IN) begin
    sync1 <= {LINE_LEVEL_IN, LINE_TOGGLE_IN, LINE_SIGNAL_PRESENT_IN, LINK_FAIL_IN,
              TXD_IN, TX_EN_IN};
    sync2 <= sync1;
  end

  assign {level, toggle, sig_present, link_fail, txd, tx_en} = sync2;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [31:0] ctl;
  logic [31:0] cfg;
  logic locked;
  prx_state_t state;
  logic rmii;
  logic speed10;
  logic half_duplex;
  logic descr_bypass;
  logic decode_bypass;

  assign rmii = ctl[`PRX_CTL_RMII];
  assign speed10 = ctl[`PRX_CTL_SPEED10];
  assign half_duplex = ctl[`PRX_CTL_HALF_DUPLEX];
  assign descr_bypass = cfg[`PRX_CFG_DESCR_BYPASS];
  assign decode_bypass = !cfg[`PRX_CFG_DECODE_ENABLE] && !rmii;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave. Address and data are taken together in one cycle.

  logic [5:0] aw_idx;
  logic [5:0] ar_idx;
  logic wr_go;
  logic rd_go;

  assign aw_idx = S_AXI_AWADDR_IN[`PRX_ADDR_W-1:`PRX_ADDR_LSB];
  assign ar_idx = S_AXI_ARADDR_IN[`PRX_ADDR_W-1:`PRX_ADDR_LSB];
  assign wr_go = S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !S_AXI_AWREADY_OUT
                 && !S_AXI_BVALID_OUT;
  assign rd_go = S_AXI_ARVALID_IN && !S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT;

  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      S_AXI_AWREADY_OUT <= 1'b0;
      S_AXI_WREADY_OUT <= 1'b0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= `PRX_RESP_OKAY;
      ctl <= `PRX_CTL_RESET;
      cfg <= `PRX_CFG_RESET;
    end else begin
      S_AXI_AWREADY_OUT <= wr_go;
      S_AXI_WREADY_OUT <= wr_go;
      if (wr_go) begin
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT <= `PRX_RESP_OKAY;
        for (int b = 0; b < 4; b++) begin
          if (S_AXI_WSTRB_IN[b]) begin
            if (aw_idx == `PRX_IDX_CONTROL) begin
              ctl[b*8 +: 8] <= S_AXI_WDATA_IN[b*8 +: 8];
            end else if (aw_idx == `PRX_IDX_CONFIG) begin
              cfg[b*8 +: 8] <= S_AXI_WDATA_IN[b*8 +: 8];
            end
          end
        end
        if (aw_idx != `PRX_IDX_CONTROL && aw_idx != `PRX_IDX_CONFIG
            && aw_idx != `PRX_IDX_STATUS) begin
          S_AXI_BRESP_OUT <= `PRX_RESP_SLVERR;
        end
      end else if (S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= 32'h0000_0000;
      S_AXI_RRESP_OUT <= `PRX_RESP_OKAY;
    end else begin
      S_AXI_ARREADY_OUT <= rd_go;
      if (rd_go) begin
        S_AXI_RVALID_OUT <= 1'b1;
        S_AXI_RRESP_OUT <= `PRX_RESP_OKAY;
        case (ar_idx)
          `PRX_IDX_CONTROL: S_AXI_RDATA_OUT <= ctl;
          `PRX_IDX_CONFIG: S_AXI_RDATA_OUT <= cfg;
          `PRX_IDX_STATUS: S_AXI_RDATA_OUT <= {27'h0, RX_DV_OUT, CRS_OUT, state, locked};
          default: begin
            S_AXI_RDATA_OUT <= 32'h0000_0000;
            S_AXI_RRESP_OUT <= `PRX_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RREADY_IN) begin
        S_AXI_RVALID_OUT <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line symbols to NRZI bits, then descrambling.

  logic toggle_d;
  logic sym_tick;
  logic [`PRX_LEVEL_W-1:0] prev_level;
  logic nrzi_bit;
  logic [10:0] key;
  logic [4:0] match_cnt;
  logic key_bit;
  logic dbit;
  logic [3:0] ones_run;
  logic [15:0] wd_cnt;
  logic wd_expired;

  assign sym_tick = toggle ^ toggle_d;
  assign nrzi_bit = (level != prev_level);
  assign key_bit = key[10] ^ key[8];
  assign dbit = descr_bypass ? nrzi_bit : (nrzi_bit ^ key_bit);
  assign wd_expired = (wd_cnt == 16'(IDLE_WINDOW_CYCLES - 1));

  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      toggle_d <= 1'b0;
      prev_level <= '0;
    end else begin
      toggle_d <= toggle;
      if (sym_tick) begin
        prev_level <= level;
      end
    end
  end

  // While unlocked the key is loaded from the inverted stream, since idle
  // plain bits are ones; lock follows a run of correct predictions.
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN || wd_expired) begin
      key <= 11'h000;
      match_cnt <= 5'd0;
      locked <= 1'b0;
    end else if (sym_tick) begin
      if (locked) begin
        key <= {key[9:0], key_bit};
      end else begin
        key <= {key[9:0], !nrzi_bit};
        if (key_bit == !nrzi_bit) begin
          if (match_cnt == `PRX_LOCK_MATCHES) begin
            locked <= 1'b1;
          end else begin
            match_cnt <= match_cnt + 5'd1;
          end
        end else begin
          match_cnt <= 5'd0;
        end
      end
    end
  end

  // The watchdog restarts whenever a run of descrambled ones marks idle.
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN || wd_expired) begin
      ones_run <= 4'd0;
      wd_cnt <= 16'd0;
    end else begin
      if (sym_tick) begin
        ones_run <= dbit ? ((ones_run == `PRX_IDLE_RUN) ? ones_run : ones_run + 4'd1)
                         : 4'd0;
      end
      if (ones_run == `PRX_IDLE_RUN || !(locked || descr_bypass)) begin
        wd_cnt <= 16'd0;
      end else begin
        wd_cnt <= wd_cnt + 16'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alignment and 5B/4B decoding.

  logic [9:0] sh;
  logic [9:0] sh_next;
  logic [2:0] bit_cnt;
  logic idle_prev;
  logic abort;
  logic group_done;
  logic [4:0] grp;
  prx_dec_t dec;
  prx_state_t next_state;
  logic [1:0] push_n;
  prx_entry_t push0;
  prx_entry_t push1;
  logic frame_start;
  logic end_frame;
  logic next_idle_prev;

  assign sh_next = {sh[8:0], dbit};
  assign grp = sh_next[4:0];
  assign dec = decode(grp);
  assign group_done = sym_tick && (bit_cnt == 3'd4);
  assign abort = wd_expired || !sig_present || link_fail;

  always_comb begin
    next_state = state;
    push_n = 2'd0;
    push0 = '0;
    push1 = '0;
    frame_start = 1'b0;
    end_frame = 1'b0;
    next_idle_prev = idle_prev;
    case (state)
      PRX_ST_HUNT: begin
        if (sym_tick && (locked || descr_bypass)
            && sh_next == {`PRX_CODE_IDLE, `PRX_CODE_J}) begin
          next_state = PRX_ST_J;
          frame_start = 1'b1;
        end
      end
      PRX_ST_J: begin
        if (group_done) begin
          push_n = (grp == `PRX_CODE_K) ? 2'd2 : 2'd1;
          if (grp == `PRX_CODE_K) begin
            next_state = PRX_ST_FRAME;
            push0 = '{dv: 1'b1, er: 1'b0, data: `PRX_NIB_PREAMBLE};
            push1 = '{dv: 1'b1, er: 1'b0, data: `PRX_NIB_PREAMBLE};
          end else begin
            next_state = PRX_ST_HUNT;
            push0 = '{dv: 1'b0, er: 1'b1, data: `PRX_NIB_BAD_SSD};
          end
          next_idle_prev = 1'b0;
        end
      end
      PRX_ST_FRAME: begin
        if (group_done) begin
          next_idle_prev = 1'b0;
          if (decode_bypass) begin
            push_n = 2'd1;
            push0 = '{dv: 1'b1, er: grp[4], data: grp[3:0]};
          end else if (dec.valid) begin
            push_n = 2'd1;
            push0 = '{dv: 1'b1, er: 1'b0, data: dec.nibble};
          end else if (grp == `PRX_CODE_T) begin
            next_state = PRX_ST_T;
          end else if (grp == `PRX_CODE_IDLE) begin
            next_idle_prev = 1'b1;
            if (idle_prev) begin
              end_frame = 1'b1;
            end
          end else begin
            push_n = 2'd1;
            push0 = '{dv: 1'b1, er: 1'b1, data: grp[3:0]};
          end
        end
      end
      PRX_ST_T: begin
        if (group_done) begin
          if (grp == `PRX_CODE_R) begin
            end_frame = 1'b1;
          end else begin
            next_state = PRX_ST_FRAME;
            push_n = 2'd1;
            push0 = '{dv: 1'b1, er: 1'b1, data: grp[3:0]};
          end
        end
      end
      default: next_state = PRX_ST_HUNT;
    endcase
    if (end_frame || abort) begin
      next_state = PRX_ST_HUNT;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      state <= PRX_ST_HUNT;
      sh <= 10'h000;
      bit_cnt <= 3'd0;
      idle_prev <= 1'b0;
    end else begin
      state <= next_state;
      idle_prev <= next_idle_prev;
      if (sym_tick) begin
        sh <= sh_next;
        bit_cnt <= (frame_start || bit_cnt == 3'd4) ? 3'd0 : bit_cnt + 3'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock dividers for the MAC side.

  logic [6:0] rx_half;
  logic [6:0] rx_div;
  logic [6:0] tx_div;
  logic rx_fall;
  logic rx_rise;
  logic tx_rise;

  assign rx_half = rmii ? `PRX_HALF_50M : (speed10 ? `PRX_HALF_2M5 : `PRX_HALF_25M);
  assign rx_fall = RX_CLK_OUT && (rx_div == 7'd0);
  assign rx_rise = !RX_CLK_OUT && (rx_div == 7'd0);
  assign tx_rise = !TX_CLK_OUT && (tx_div == 7'd0);

  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      RX_CLK_OUT <= 1'b0;
      rx_div <= 7'd0;
    end else if (frame_start && sig_present) begin
      RX_CLK_OUT <= 1'b0;
      rx_div <= rx_half - 7'd1;
    end else if (rx_div == 7'd0) begin
      RX_CLK_OUT <= !RX_CLK_OUT;
      rx_div <= rx_half - 7'd1;
    end else begin
      rx_div <= rx_div - 7'd1;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      TX_CLK_OUT <= 1'b0;
      tx_div <= 7'd0;
    end else if (tx_div == 7'd0) begin
      TX_CLK_OUT <= !TX_CLK_OUT;
      tx_div <= `PRX_HALF_2M5 - 7'd1;
    end else begin
      tx_div <= tx_div - 7'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit capture at 10 Mb/s.

  logic [1:0] tx_low;
  logic tx_half;
  logic tx_take;
  logic [3:0] tx_nib;

  // RMII pairs two di-bits, low pair first, from one reference rising edge
  // to the next; a drop of TX_EN discards a half-built nibble.
  always_comb begin
    tx_take = 1'b0;
    tx_nib = txd;
    if (rmii) begin
      tx_take = rx_rise && tx_en && tx_half;
      tx_nib = {txd[1:0], tx_low};
    end else begin
      tx_take = tx_rise && tx_en;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      tx_low <= 2'b00;
      tx_half <= 1'b0;
      TX_NIBBLE_OUT <= 4'h0;
      TX_NIBBLE_VALID_OUT <= 1'b0;
      COL_OUT <= 1'b0;
    end else begin
      if (rmii && rx_rise) begin
        tx_half <= tx_en && !tx_half;
        tx_low <= tx_en ? txd[1:0] : 2'b00;
      end
      TX_NIBBLE_VALID_OUT <= tx_take && speed10;
      if (tx_take && speed10) begin
        TX_NIBBLE_OUT <= tx_nib;
      end
      COL_OUT <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive queue and MAC-side launch.

  localparam int QW = $clog2(QUEUE_DEPTH);
  prx_entry_t queue [QUEUE_DEPTH];
  logic [QW-1:0] wr_ptr;
  logic [QW-1:0] rd_ptr;
  logic [QW:0] q_cnt;
  logic loop_push;
  logic pop;
  logic rx_phase;
  prx_entry_t cur;
  logic [1:0] n_push;

  assign loop_push = tx_take && speed10 && half_duplex && !rmii;
  assign n_push = loop_push ? 2'd1 : push_n;
  assign pop = rx_fall && (q_cnt != '0) && (!rmii || !rx_phase);

  // An overflowing push is dropped; the launch rate matches the symbol rate.
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN || abort) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      q_cnt <= '0;
    end else begin
      if (n_push != 2'd0 && q_cnt + (QW+1)'(n_push) <= (QW+1)'(QUEUE_DEPTH)) begin
        queue[wr_ptr] <= loop_push ? '{dv: 1'b1, er: 1'b0, data: tx_nib} : push0;
        if (n_push == 2'd2) begin
          queue[wr_ptr + QW'(1)] <= push1;
        end
        wr_ptr <= wr_ptr + QW'(n_push);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + QW'(1);
      end
      q_cnt <= q_cnt + ((n_push != 2'd0 && q_cnt + (QW+1)'(n_push) <= (QW+1)'(QUEUE_DEPTH))
               ? (QW+1)'(n_push) : '0) - (pop ? (QW+1)'(1) : '0);
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      cur <= '0;
      rx_phase <= 1'b0;
      RXD_OUT <= 4'h0;
      RX_DV_OUT <= 1'b0;
      RX_ER_OUT <= 1'b0;
      CRS_OUT <= 1'b0;
    end else begin
      CRS_OUT <= (state != PRX_ST_HUNT) || (q_cnt != '0) || loop_push;
      if (abort) begin
        RX_DV_OUT <= 1'b0;
        RX_ER_OUT <= 1'b0;
        rx_phase <= 1'b0;
      end else if (rx_fall) begin
        if (rmii && rx_phase) begin
          RXD_OUT <= {2'b00, cur.data[3:2]};
          rx_phase <= 1'b0;
        end else begin
          cur <= (q_cnt != '0) ? queue[rd_ptr] : '0;
          RX_DV_OUT <= (q_cnt != '0) && queue[rd_ptr].dv;
          RX_ER_OUT <= (q_cnt != '0) && queue[rd_ptr].er;
          RXD_OUT <= (q_cnt == '0) ? 4'h0 : rmii ? {2'b00, queue[rd_ptr].data[1:0]}
                                                  : queue[rd_ptr].data;
          rx_phase <= rmii && (q_cnt != '0);
        end
      end
    end
  end

endmodule

`default_nettype wire
